// >>> hw/dtp_timer.sv
// dual timer / pwm block with apb register access
//
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - each unit times everything from its own 16-bit counter behind a prescaler
// - one bit per unit turns all its channels not set off into center-aligned pwm
// - each channel is capture, compare or buffered edge pwm on its own
// - capture latches the counter on rising, falling or either pin edge
// - a compare match sets, clears or toggles the channel pin
// - each pwm channel has its own output polarity bit
// - each unit picks bus clock, fixed system clock or external pin
// - prescaler divides by one up to 128 in eight power-of-two steps
// - counter counts up freely, or up and down in center mode
// - a 16-bit modulus sets the counter range and overflow period
// - one interrupt source per channel plus one per terminal count
// - with the clock generator on an external source, fixed system clock runs at reference oscillator rate over two
// - first unit has five channels, four pinned; second three, one pinned
// - one shared pin per pinned channel, driven only while the channel is in compare or pwm mode
// - external bypass mode takes system clock straight from external source
// - clock generator leaves reset in self-clocked mode
module dtp_timer (
  input wire logic pclk, // bus clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  input wire logic [1:0] ext_clk, // external count clock per unit
  input wire logic reference_oscillator_clock, // reference oscillator
  input wire logic [4:0] timer_channel_pin_i, // pin levels
  output logic [4:0] timer_channel_pin_o, // pin drive values
  output logic [4:0] timer_channel_pin_oe, // pin owned by timer
  output logic ext_bypass_active, // system clock from external source
  output logic irq // level interrupt
);
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [4:0] pin_o_reg;
  logic [4:0] pin_oe_reg;
  logic bypass_reg;
  logic irq_reg;
  logic [9:0] status_reg;
  logic [9:0] mask_reg;
  logic [9:0] events;
  dtp_pkg::dtp_clkgen_t clkgen_reg;
  dtp_pkg::dtp_unit_ctrl_t uctrl_reg [2];
  logic [15:0] cnt_reg [2];
  logic [15:0] mod_reg [2];
  logic [6:0] ps_reg [2];
  logic down_reg [2];
  logic [1:0] utick;
  logic [1:0] boundary;
  dtp_pkg::dtp_ch_ctrl_t cctrl_reg [8];
  logic [15:0] cv_reg [8];
  logic [15:0] duty_reg [8];
  logic [7:0] ch_out;
  logic [7:0] ch_oe;
  logic [2:0] sync_reg [8];
  logic [7:0] lvl_reg;
  logic [7:0] lvl_d_reg;
  logic [7:0] rise;
  logic [7:0] fall;
  logic [7:0] sync_in;
  logic fix_half_reg;
  logic fix_tick_reg;
  logic access;
  logic wr_en;
  logic [31:0] rd_next;
  logic hit;

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign timer_channel_pin_o = pin_o_reg;
  assign timer_channel_pin_oe = pin_oe_reg;
  assign ext_bypass_active = bypass_reg;
  assign irq = irq_reg;

  // zero-wait slave: answer in the first access cycle
  assign access = psel & penable & pready_reg;
  assign wr_en = access & pwrite & hit;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end
    else
    begin
      pready_reg <= psel & ~penable;
      pslverr_reg <= psel & ~penable & ~hit;
      prdata_reg <= (psel & ~penable & ~pwrite) ? rd_next : 32'h0000_0000;
    end
  end

  always_comb
  begin
    rd_next = 32'h0000_0000;
    hit = 1'b0;
    for (int u = 0; u < dtp_pkg::NUM_UNITS; u++)
    begin
      if (paddr == dtp_pkg::OFS_SC + 12'(u) * dtp_pkg::UNIT_STRIDE)
      begin
        hit = 1'b1;
        rd_next = {25'h0, uctrl_reg[u]};
      end
      if (paddr == dtp_pkg::OFS_CNT + 12'(u) * dtp_pkg::UNIT_STRIDE)
      begin
        hit = 1'b1;
        rd_next = {16'h0, cnt_reg[u]};
      end
      if (paddr == dtp_pkg::OFS_MOD + 12'(u) * dtp_pkg::UNIT_STRIDE)
      begin
        hit = 1'b1;
        rd_next = {16'h0, mod_reg[u]};
      end
    end
    for (int c = 0; c < dtp_pkg::NUM_CH; c++)
    begin
      if (paddr == dtp_pkg::CH_BASE + 12'(c) * dtp_pkg::CH_STRIDE +
          dtp_pkg::OFS_CSC)
      begin
        hit = 1'b1;
        rd_next = {27'h0, cctrl_reg[c]};
      end
      if (paddr == dtp_pkg::CH_BASE + 12'(c) * dtp_pkg::CH_STRIDE +
          dtp_pkg::OFS_CV)
      begin
        hit = 1'b1;
        rd_next = {16'h0, cv_reg[c]};
      end
    end
    if (paddr == dtp_pkg::OFS_STATUS)
    begin
      hit = 1'b1;
      rd_next = {22'h0, status_reg};
    end
    if (paddr == dtp_pkg::OFS_MASK)
    begin
      hit = 1'b1;
      rd_next = {22'h0, mask_reg};
    end
    if (paddr == dtp_pkg::OFS_CLKGEN)
    begin
      hit = 1'b1;
      rd_next = {30'h0, clkgen_reg};
    end
  end

  // bypass flag follows clock generator mode
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      clkgen_reg <= dtp_pkg::CG_SELF;
      bypass_reg <= 1'b0;
    end
    else
    begin
      if (wr_en && paddr == dtp_pkg::OFS_CLKGEN)
        clkgen_reg <= dtp_pkg::dtp_clkgen_t'(pwdata[1:0]);
      bypass_reg <= (clkgen_reg == dtp_pkg::CG_EXT_BYP);
    end
  end

  // sticky events, set beats a same-cycle clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status_reg <= 10'h000;
      mask_reg <= 10'h000;
      irq_reg <= 1'b0;
    end
    else
    begin
      if (wr_en && paddr == dtp_pkg::OFS_STATUS)
        status_reg <= (status_reg & ~pwdata[9:0]) | events;
      else
        status_reg <= status_reg | events;
      if (wr_en && paddr == dtp_pkg::OFS_MASK)
        mask_reg <= pwdata[9:0];
      irq_reg <= |(status_reg & mask_reg);
    end
  end

  // pin and clock inputs: three flops, change taken when last two agree
  assign sync_in = {timer_channel_pin_i, reference_oscillator_clock, ext_clk};
  assign rise = lvl_reg & ~lvl_d_reg;
  assign fall = ~lvl_reg & lvl_d_reg;
  genvar s;
  generate
    for (s = 0; s < dtp_pkg::NSYNC; s++)
    begin : g_sync
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          sync_reg[s] <= 3'h0;
          lvl_reg[s] <= 1'b0;
          lvl_d_reg[s] <= 1'b0;
        end
        else
        begin
          sync_reg[s] <= {sync_reg[s][1:0], sync_in[s]};
          if (sync_reg[s][1] == sync_reg[s][2])
            lvl_reg[s] <= sync_reg[s][2];
          lvl_d_reg[s] <= lvl_reg[s];
        end
      end
    end
  endgenerate

  // one tick every second rising reference edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fix_half_reg <= 1'b0;
      fix_tick_reg <= 1'b0;
    end
    else
    begin
      if (rise[dtp_pkg::SYNC_REF])
        fix_half_reg <= ~fix_half_reg;
      fix_tick_reg <= rise[dtp_pkg::SYNC_REF] & fix_half_reg;
    end
  end

  genvar u;
  generate
    for (u = 0; u < dtp_pkg::NUM_UNITS; u++)
    begin : g_unit
      logic src_tick;
      logic [6:0] ps_mask;
      logic [15:0] top;
      logic at_top;
      // fixed clock is dead unless clock generator uses external source
      always_comb
      begin
        case (uctrl_reg[u].clksel)
          dtp_pkg::CLK_BUS: src_tick = 1'b1;
          dtp_pkg::CLK_FIXED: src_tick = fix_tick_reg &
            (clkgen_reg == dtp_pkg::CG_EXT_BYP ||
             clkgen_reg == dtp_pkg::CG_EXT_ENG);
          dtp_pkg::CLK_EXT: src_tick = rise[u];
          default: src_tick = 1'b0;
        endcase
      end
      // divide by two to the power presc
      assign ps_mask = dtp_pkg::PS_ALL >> (3'h7 - uctrl_reg[u].presc);
      assign utick[u] = uctrl_reg[u].enable & src_tick &
        ((ps_reg[u] & ps_mask) == ps_mask);
      // modulus zero leaves full 16-bit range
      assign top = (mod_reg[u] == dtp_pkg::CNT_ZERO) ? dtp_pkg::CNT_MAX :
        mod_reg[u];
      assign at_top = (cnt_reg[u] >= top);
      assign boundary[u] = utick[u] & at_top & ~(uctrl_reg[u].center &
        down_reg[u]);
      assign events[dtp_pkg::TOF_BIT0 + u] = boundary[u];
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          uctrl_reg[u] <= dtp_pkg::UNIT_CTRL_RST;
          mod_reg[u] <= dtp_pkg::CNT_ZERO;
        end
        else if (wr_en)
        begin
          if (paddr == dtp_pkg::OFS_SC + 12'(u) * dtp_pkg::UNIT_STRIDE)
            uctrl_reg[u] <= dtp_pkg::dtp_unit_ctrl_t'(pwdata[6:0]);
          if (paddr == dtp_pkg::OFS_MOD + 12'(u) * dtp_pkg::UNIT_STRIDE)
            mod_reg[u] <= pwdata[15:0];
        end
      end
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          ps_reg[u] <= 7'h00;
          cnt_reg[u] <= dtp_pkg::CNT_ZERO;
          down_reg[u] <= 1'b0;
        end
        else if (wr_en &&
          paddr == dtp_pkg::OFS_CNT + 12'(u) * dtp_pkg::UNIT_STRIDE)
        begin
          // any write restarts the count from zero
          ps_reg[u] <= 7'h00;
          cnt_reg[u] <= dtp_pkg::CNT_ZERO;
          down_reg[u] <= 1'b0;
        end
        else
        begin
          if (uctrl_reg[u].enable & src_tick)
            ps_reg[u] <= ps_reg[u] + dtp_pkg::PS_ONE;
          if (utick[u])
          begin
            // center bit reshapes the whole unit
            if (uctrl_reg[u].center)
            begin
              if (!down_reg[u] && at_top)
              begin
                down_reg[u] <= 1'b1;
                cnt_reg[u] <= cnt_reg[u] - dtp_pkg::CNT_ONE;
              end
              else if (down_reg[u] && cnt_reg[u] == dtp_pkg::CNT_ZERO)
              begin
                down_reg[u] <= 1'b0;
                cnt_reg[u] <= dtp_pkg::CNT_ONE;
              end
              else if (down_reg[u])
                cnt_reg[u] <= cnt_reg[u] - dtp_pkg::CNT_ONE;
              else
                cnt_reg[u] <= cnt_reg[u] + dtp_pkg::CNT_ONE;
            end
            else if (at_top)
            begin
              down_reg[u] <= 1'b0;
              cnt_reg[u] <= dtp_pkg::CNT_ZERO;
            end
            else
            begin
              down_reg[u] <= 1'b0;
              cnt_reg[u] <= cnt_reg[u] + dtp_pkg::CNT_ONE;
            end
          end
        end
      end
    end
  endgenerate

  // channels 0-4 on unit 0, 5-7 on unit 1
  genvar c;
  generate
    for (c = 0; c < dtp_pkg::NUM_CH; c++)
    begin : g_ch
      localparam int U = (c < dtp_pkg::UNIT0_CH) ? 0 : 1;
      localparam int P = (c < 4) ? c : 4;
      localparam bit PINNED = (c < 4) || (c == dtp_pkg::PIN_CH4);
      logic edge_hit;
      logic cap_ev;
      logic cmp_ev;
      logic active;
      logic is_pwm;
      logic cv_wr;
      logic out_reg;
      // internal channels see no pin
      assign edge_hit = PINNED &&
        ((cctrl_reg[c].sel == dtp_pkg::SEL_RISE &&
          rise[dtp_pkg::SYNC_PIN0 + P]) ||
         (cctrl_reg[c].sel == dtp_pkg::SEL_FALL &&
          fall[dtp_pkg::SYNC_PIN0 + P]) ||
         (cctrl_reg[c].sel == dtp_pkg::SEL_BOTH &&
          (rise[dtp_pkg::SYNC_PIN0 + P] | fall[dtp_pkg::SYNC_PIN0 + P])));
      // mode per channel, center bit overrides to pwm
      assign is_pwm = uctrl_reg[U].center ?
        (cctrl_reg[c].mode != dtp_pkg::CH_OFF) :
        (cctrl_reg[c].mode == dtp_pkg::CH_PWM);
      assign cap_ev = ~uctrl_reg[U].center & edge_hit &
        (cctrl_reg[c].mode == dtp_pkg::CH_CAPTURE);
      assign cmp_ev = ~uctrl_reg[U].center & utick[U] &
        (cctrl_reg[c].mode == dtp_pkg::CH_COMPARE) &
        (cnt_reg[U] == cv_reg[c]);
      assign events[c] = cap_ev | cmp_ev | (is_pwm & boundary[U]);
      assign active = cnt_reg[U] < duty_reg[c];
      assign cv_wr = wr_en && paddr == dtp_pkg::CH_BASE +
        12'(c) * dtp_pkg::CH_STRIDE + dtp_pkg::OFS_CV;
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          cctrl_reg[c] <= dtp_pkg::CH_CTRL_RST;
          cv_reg[c] <= dtp_pkg::CNT_ZERO;
        end
        else
        begin
          if (wr_en && paddr == dtp_pkg::CH_BASE +
            12'(c) * dtp_pkg::CH_STRIDE + dtp_pkg::OFS_CSC)
            cctrl_reg[c] <= dtp_pkg::dtp_ch_ctrl_t'(pwdata[4:0]);
          // capture wins over a same-cycle software write
          if (cap_ev)
            cv_reg[c] <= cnt_reg[U];
          else if (cv_wr)
            cv_reg[c] <= pwdata[15:0];
        end
      end
      // duty buffer reloads at period boundary, and every cycle while the channel is not pwm
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          duty_reg[c] <= dtp_pkg::CNT_ZERO;
        else if (boundary[U] || !is_pwm)
          duty_reg[c] <= cv_reg[c];
      end
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          out_reg <= 1'b0;
        else if (is_pwm)
          out_reg <= cctrl_reg[c].pol ? active : ~active;
        else if (cmp_ev)
        begin
          case (cctrl_reg[c].sel)
            dtp_pkg::ACT_CLEAR: out_reg <= 1'b0;
            dtp_pkg::ACT_SET: out_reg <= 1'b1;
            dtp_pkg::ACT_TOGGLE: out_reg <= ~out_reg;
            default: out_reg <= out_reg;
          endcase
        end
      end
      assign ch_out[c] = out_reg;
      assign ch_oe[c] = is_pwm | (cctrl_reg[c].mode == dtp_pkg::CH_COMPARE);
    end
  endgenerate

  // pin owned only while channel drives it
  genvar p;
  generate
    for (p = 0; p < dtp_pkg::NUM_PINS; p++)
    begin : g_pin
      localparam int CH = (p < 4) ? p : dtp_pkg::PIN_CH4;
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          pin_o_reg[p] <= 1'b0;
          pin_oe_reg[p] <= 1'b0;
        end
        else
        begin
          pin_o_reg[p] <= ch_out[CH];
          pin_oe_reg[p] <= ch_oe[CH];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// >>> hw/dtp_pkg.sv
// constants and types shared by the dual timer / pwm block
package dtp_pkg;
  localparam int NUM_UNITS = 2;
  localparam int NUM_CH = 8;
  localparam int UNIT0_CH = 5;
  localparam int NUM_PINS = 5;
  localparam int NSYNC = 8;
  localparam int STAT_W = 10;
  localparam int TOF_BIT0 = 8;
  localparam int PIN_CH4 = 5;
  localparam int SYNC_REF = 2;
  localparam int SYNC_PIN0 = 3;
  localparam int CNT_W = 16;
  localparam int PS_W = 7;
  localparam logic [11:0] OFS_SC = 12'h000;
  localparam logic [11:0] OFS_CNT = 12'h004;
  localparam logic [11:0] OFS_MOD = 12'h008;
  localparam logic [11:0] UNIT_STRIDE = 12'h040;
  localparam logic [11:0] CH_BASE = 12'h080;
  localparam logic [11:0] CH_STRIDE = 12'h008;
  localparam logic [11:0] OFS_CSC = 12'h000;
  localparam logic [11:0] OFS_CV = 12'h004;
  localparam logic [11:0] OFS_STATUS = 12'h0C0;
  localparam logic [11:0] OFS_MASK = 12'h0C4;
  localparam logic [11:0] OFS_CLKGEN = 12'h0C8;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [6:0] PS_ONE = 7'h01;
  localparam logic [6:0] PS_ALL = 7'h7F;
  typedef enum logic [1:0] {
    CLK_OFF = 2'b00, CLK_BUS = 2'b01, CLK_FIXED = 2'b10, CLK_EXT = 2'b11
  } dtp_clksel_t;
  typedef enum logic [1:0] {
    CH_OFF = 2'b00, CH_CAPTURE = 2'b01, CH_COMPARE = 2'b10, CH_PWM = 2'b11
  } dtp_chmode_t;
  typedef enum logic [1:0] {
    CG_SELF = 2'b00, CG_INT_ENG = 2'b01, CG_EXT_BYP = 2'b10,
    CG_EXT_ENG = 2'b11
  } dtp_clkgen_t;
  localparam logic [1:0] SEL_RISE = 2'b01;
  localparam logic [1:0] SEL_FALL = 2'b10;
  localparam logic [1:0] SEL_BOTH = 2'b11;
  localparam logic [1:0] ACT_CLEAR = 2'b01;
  localparam logic [1:0] ACT_SET = 2'b10;
  localparam logic [1:0] ACT_TOGGLE = 2'b11;
  typedef struct packed {
    logic enable;
    logic center;
    dtp_clksel_t clksel;
    logic [2:0] presc;
  } dtp_unit_ctrl_t;
  typedef struct packed {
    logic pol;
    logic [1:0] sel;
    dtp_chmode_t mode;
  } dtp_ch_ctrl_t;
  localparam dtp_unit_ctrl_t UNIT_CTRL_RST = '{1'b0, 1'b0, CLK_BUS, 3'h0};
  localparam dtp_ch_ctrl_t CH_CTRL_RST = '{1'b1, 2'b00, CH_OFF};
endpackage

// >>> test/dtp_timer_sva.sv
// concurrent checks on the dual timer / pwm block ports
`timescale 1ns/1ps
`default_nettype none
module dtp_timer_sva (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access
  input wire logic pwrite, // apb write
  input wire logic [11:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [31:0] prdata, // apb read data
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic [4:0] timer_channel_pin_oe, // pin owned
  input wire logic ext_bypass_active, // bypass mode
  input wire logic irq // interrupt
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence wr_s(logic [11:0] a);
    psel && penable && pwrite && paddr == a;
  endsequence
  ready_one_a:
    assert property (setup_s |=> pready)
    else $error("ready missing after setup");
  ready_pulse_a:
    assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  ready_access_a:
    assert property (pready |-> psel && penable && $past(psel && !penable))
    else $error("ready outside access phase");
  refused_zero_a:
    assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error response malformed");
  idle_rdata_a:
    assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  mask_off_a:
    assert property (wr_s(dtp_pkg::OFS_MASK) ##0 pwdata[9:0] == 10'h000
      |-> ##2 !irq)
    else $error("irq high with all sources masked");
  bypass_on_a:
    assert property (wr_s(dtp_pkg::OFS_CLKGEN) ##0 pwdata[1:0] == 2'h2
      |-> ##[1:2] ext_bypass_active)
    else $error("bypass mode not shown");
  boot_mode_a:
    assert property ($rose(presetn) |-> !ext_bypass_active)
    else $error("clock generator not self clocked after reset");
  oe_by_write_a:
    assert property (!$stable(timer_channel_pin_oe)
      |-> $past(psel && penable && pwrite)
      || $past(psel && penable && pwrite, 2))
    else $error("pin ownership changed without a write");
endmodule
bind dtp_timer dtp_timer_sva u_sva (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .timer_channel_pin_oe(timer_channel_pin_oe),
  .ext_bypass_active(ext_bypass_active),
  .irq(irq)
);
`default_nettype wire

// >>> test/dtp_pin_model.sv
// outside world on the shared channel pins and count clocks
`timescale 1ns/1ps
`default_nettype none
module dtp_pin_model (
  input wire logic pclk, // bench clock
  input wire logic [4:0] level, // level driven from outside
  input wire logic [4:0] pin_o, // timer drive value
  input wire logic [4:0] pin_oe, // timer owns pin
  output logic [4:0] pin_i, // resolved pin level
  output logic [1:0] ext_clk, // external count clock
  output logic ref_clk // reference oscillator
);
  int n = 0;
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & level);
  // clock sources
  // every level lasts two cycles or more, else the input filter drops it
  always @(posedge pclk)
  begin
    n <= n + 1;
    ref_clk <= n[1];
    ext_clk <= {2{n[2]}};
  end
endmodule
`default_nettype wire

// >>> test/tb.sv
// self-checking bench for the dual timer / pwm block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
  compares++; \
  if ((g) !== (e)) \
  begin \
    fail_count++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); \
  end
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, rerr, ext_bypass_active, irq, ref_clk, v;
  logic [1:0] ext_clk;
  logic [4:0] level = 5'h00, pin_i, pin_o, pin_oe;
  int fail_count = 0, compares = 0, cyc = 0, t1, m, d, h;
  always #5 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;
  dtp_timer u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_clk(ext_clk),
    .reference_oscillator_clock(ref_clk), .timer_channel_pin_i(pin_i),
    .timer_channel_pin_o(pin_o), .timer_channel_pin_oe(pin_oe),
    .ext_bypass_active(ext_bypass_active), .irq(irq)
  );
  dtp_pin_model u_pins (
    .pclk(pclk), .level(level), .pin_o(pin_o), .pin_oe(pin_oe),
    .pin_i(pin_i), .ext_clk(ext_clk), .ref_clk(ref_clk)
  );
  function automatic logic [11:0] ub(input int u);
    return 12'(u) * dtp_pkg::UNIT_STRIDE;
  endfunction
  function automatic logic [11:0] cb(input int c);
    return dtp_pkg::CH_BASE + 12'(c) * dtp_pkg::CH_STRIDE;
  endfunction
  // cycles between terminal counts at one tick per cycle
  function automatic int per(input int mod, input bit center);
    return center ? 2 * mod : mod + 1;
  endfunction
  task automatic tick(input int k);
    repeat (k) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] dat);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= dat;
    @(posedge pclk);
    penable <= 1'b1;
    // no local limit: only the watchdog ends a hung transfer
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK("register", e, rd)
  endtask
  task automatic waitirq;
    while (irq !== 1'b1)
    begin
      @(posedge pclk);
    end
  endtask
  // time two terminal counts apart through the interrupt line
  task automatic period(input int u, input logic [31:0] scv, input int e);
    apb(1'b1, ub(u) + dtp_pkg::OFS_MOD, m);
    apb(1'b1, ub(u) + dtp_pkg::OFS_CNT, 32'h0);
    apb(1'b1, dtp_pkg::OFS_MASK, 32'h300);
    apb(1'b1, dtp_pkg::OFS_STATUS, 32'h300);
    apb(1'b1, ub(u) + dtp_pkg::OFS_SC, scv);
    waitirq();
    t1 = cyc;
    apb(1'b1, dtp_pkg::OFS_STATUS, 32'h300);
    tick(2);
    waitirq();
    `CHK("period", e, cyc - t1)
    apb(1'b1, ub(u) + dtp_pkg::OFS_SC, 32'h0);
    apb(1'b1, dtp_pkg::OFS_MASK, 32'h0);
    tick(2);
    `CHK("masked irq", 1'b0, irq)
  endtask
  task automatic hcount;
    h = 0;
    repeat (m + 1)
    begin
      @(posedge pclk);
      h += int'(pin_o[1] === 1'b1);
    end
  endtask
  task conclude;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    void'($urandom(88300));
    tick(4);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk(ub(0) + dtp_pkg::OFS_SC, 32'h08);
    rdchk(ub(1) + dtp_pkg::OFS_SC, 32'h08);
    for (int c = 0; c < 8; c++)
      rdchk(cb(c), 32'h10);
    rdchk(dtp_pkg::OFS_CLKGEN, 32'h0);
    apb(1'b1, 12'h0FC, 32'h1);
    `CHK("unmapped", 1'b1, rerr)
    apb(1'b1, dtp_pkg::OFS_CLKGEN, 32'h2);
    tick(3);
    `CHK("bypass", 1'b1, ext_bypass_active)
    // mid-run reset must fall back to self-clocked mode
    presetn <= 1'b0;
    tick(2);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK("bypass after reset", 1'b0, ext_bypass_active)
    rdchk(dtp_pkg::OFS_CLKGEN, 32'h0);
    // fixed source must stay idle while self-clocked
    apb(1'b1, ub(1) + dtp_pkg::OFS_SC, 32'h50);
    tick(40);
    rdchk(ub(1) + dtp_pkg::OFS_CNT, 32'h0);
    apb(1'b1, ub(1) + dtp_pkg::OFS_SC, 32'h0);
    // fixed clock only runs with the clock generator on an external source, bypassed or engaged
    apb(1'b1, dtp_pkg::OFS_CLKGEN, 32'h3);
    for (int p = 0; p < 8; p++)
    begin
      m = 20 + $urandom % 8;
      period(p % 2, 32'h48 | p, per(m, 1'b0) << p);
    end
    m = 20 + $urandom % 8;
    period(0, 32'h68, per(m, 1'b1));
    // reference period is four cycles, so a fixed tick every eight
    period(1, 32'h50, per(m, 1'b0) * 8);
    period(0, 32'h58, per(m, 1'b0) * 8);
    m = 20;
    apb(1'b1, dtp_pkg::OFS_MOD, m);
    apb(1'b1, dtp_pkg::OFS_SC, 32'h48);
    apb(1'b1, cb(0) + dtp_pkg::OFS_CV, 32'h5);
    for (int act = 1; act < 4; act++)
    begin
      apb(1'b1, cb(0), 32'(act * 4 + 2));
      tick(2 * (m + 1));
      v = pin_o[0];
      tick(m + 1);
      `CHK("pin owned", 1'b1, pin_oe[0])
      `CHK("compare", act == 1 ? 1'b0 : act == 2 ? 1'b1 : ~v, pin_o[0])
    end
    // second pass writes duty while pwm runs, so it waits for a boundary
    for (int pol = 1; pol >= 0; pol--)
    begin
      d = 1 + $urandom % m;
      apb(1'b1, cb(1) + dtp_pkg::OFS_CV, d);
      apb(1'b1, cb(1), 32'(pol * 16 + 3));
      tick(2 * (m + 1));
      hcount();
      `CHK("pwm high", pol ? d : m + 1 - d, h)
    end
    for (int s = 1; s < 4; s++)
    begin
      level[2] <= 1'b0;
      apb(1'b1, cb(2), 32'(s * 4 + 1));
      tick(10);
      apb(1'b1, dtp_pkg::OFS_STATUS, 32'h4);
      level[2] <= 1'b1;
      tick(10);
      apb(1'b0, dtp_pkg::OFS_STATUS, 32'h0);
      `CHK("rise capture", s[0], rd[2])
      apb(1'b1, dtp_pkg::OFS_STATUS, 32'h4);
      level[2] <= 1'b0;
      tick(10);
      apb(1'b0, dtp_pkg::OFS_STATUS, 32'h0);
      `CHK("fall capture", s[1], rd[2])
      apb(1'b0, cb(2) + dtp_pkg::OFS_CV, 32'h0);
      `CHK("captured", 1'b1, rd <= m)
    end
    conclude();
  end
  initial
  begin
    // tests need about 17k cycles; allow a wide margin
    #400000;
    fail_count++;
    conclude();
  end
endmodule
`default_nettype wire
